/* snl_regs.svh */
// Register numbers, field positions, reset values and counts of the switch node config bank
`ifndef SNL_REGS_SVH
`define SNL_REGS_SVH

`define SNL_REG_NODE_ID 8'h05
`define SNL_REG_SW_DIV 8'h07
`define SNL_REG_REF_DIV 8'h08
`define SNL_REG_DEV_ID 8'h09
`define SNL_REG_USER_CODE 8'h0a
`define SNL_REG_DIR_LO 8'h0c
`define SNL_REG_DIR_HI 8'h0d
`define SNL_REG_RSV_A 8'h10
`define SNL_REG_RSV_B 8'h11
`define SNL_REG_DBG_SRC 8'h1f
`define SNL_REG_XSTAT 8'h20
`define SNL_REG_PSTAT 8'h40
`define SNL_REG_XCTL 8'h80

`define SNL_SW_DIV_RST 16'h0000
`define SNL_REF_DIV_RST 16'h0003
`define SNL_NODE_ID_RST 16'h0000

`define SNL_UC_OTP_LSB 18
`define SNL_STAT_SRC_LSB 24
`define SNL_STAT_DEST_LSB 16
`define SNL_STAT_DIR_LSB 8
`define SNL_STAT_NET_LSB 4
`define SNL_STAT_JUNK_BIT 2
`define SNL_STAT_DBUSY_BIT 1
`define SNL_STAT_SBUSY_BIT 0
`define SNL_CTL_EN_BIT 31
`define SNL_CTL_FIVE_BIT 30
`define SNL_CTL_ERR_BIT 27
`define SNL_CTL_ISSUED_BIT 26
`define SNL_CTL_CREDIT_BIT 25
`define SNL_CTL_TOKEN_A_BIT 24
`define SNL_CTL_RXRST_BIT 23
`define SNL_CTL_SYMGAP_LSB 11
`define SNL_CTL_TOKGAP_LSB 0
`define SNL_DBG_RSV_BIT 4

`define SNL_DIR_ENTRIES 8
`define SNL_DIR_W 4

`endif

/* snl_pkg.sv */
// Types shared by the switch node config bank
package snl_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } snl_cfg_req_t;

  typedef struct packed {
    logic [1:0] src_type;
    logic [7:0] dest_link;
    logic junk;
    logic dest_busy;
    logic src_busy;
  } snl_lstat_t;

  typedef struct packed {
    logic enable;
    logic five_wire;
    logic [10:0] sym_gap;
    logic [10:0] tok_gap;
    logic credit;
    logic [11:0] gap_cnt;
    logic token_a;
    logic rx_reset;
    logic tx_ok;
    logic [3:0] dir;
    logic [1:0] net;
  } snl_xlink_t;

endpackage : snl_pkg

/* snl_config_top.sv */
// Switch node configuration and link control register bank
//
// Functional notes
// - Switch clock tick from divider, reset zero
// - Reference clock tick from divider, reset three
// - User code: OTP bits high, metal ID low
// - Low table covers mismatch bits seven..zero
// - Direction from most significant mismatching bit
// - High table covers mismatch bits fifteen..eight
// - Entry k at bits 4k+3:4k, reset zero
// - Debug source bits name raising tile, writable
// - Status reports source target type code
// - Status reports destination link number
// - External status holds direction field, reset zero
// - Link status holds network number, reset zero
// - Status bits junk, dest busy, source busy
// - Processor link status without direction field
// - Control top bit enables external link
// - Bit thirty selects two or five wire
// - Bit twenty-seven reports receive error
// - Credit bits shown; transmit only with credit
// - Bit twenty-four clears credit, sends token_a
// - Bit twenty-three resets link receiver
// - Symbol gap at least field plus one
// - Token gap at least field plus one
// - Node identifier, reset zero, compared for routing
`timescale 1ns/1ps
`include "snl_regs.svh"

module snl_config_top #(
  parameter int NUM_XLINKS = 9,
  parameter int NUM_PLINKS = 8,
  // Arbitrary neutral value
  parameter logic [31:0] DEVICE_ID = 32'h0000_0001
) (
  input wire logic CORE_CLK_IN,
  input wire logic SRST_IN,
  input wire logic CLK_EN_IN,
  input wire snl_pkg::snl_cfg_req_t CFG_REQ_IN,
  output logic [31:0] CFG_RDATA_OUT,
  output logic CFG_RVALID_OUT,
  input wire logic [13:0] OTP_USER_CODE_IN,
  input wire logic [17:0] METAL_ID_IN,
  input wire logic [1:0] DBG_EVENT_IN,
  input wire logic ROUTE_REQ_IN,
  input wire logic [15:0] ROUTE_DEST_ID_IN,
  output logic ROUTE_VALID_OUT,
  output logic [3:0] ROUTE_DIR_OUT,
  output logic ROUTE_LOCAL_OUT,
  output logic SWITCH_TICK_OUT,
  output logic REF_TICK_OUT,
  input wire snl_pkg::snl_lstat_t [NUM_XLINKS-1:0] XL_STAT_IN,
  input wire snl_pkg::snl_lstat_t [NUM_PLINKS-1:0] PL_STAT_IN,
  input wire logic [NUM_XLINKS-1:0] XL_ERR_IN,
  input wire logic [NUM_XLINKS-1:0] XL_CREDIT_ISSUED_IN,
  input wire logic [NUM_XLINKS-1:0] XL_CREDIT_GOT_IN,
  input wire logic [NUM_XLINKS-1:0] XL_SYM_SENT_IN,
  input wire logic [NUM_XLINKS-1:0] XL_TOK_SENT_IN,
  output logic [NUM_XLINKS-1:0] XL_ENABLE_OUT,
  output logic [NUM_XLINKS-1:0] XL_FIVE_WIRE_OUT,
  output logic [NUM_XLINKS-1:0] XL_TOKEN_A_OUT,
  output logic [NUM_XLINKS-1:0] XL_RX_RESET_OUT,
  output logic [NUM_XLINKS-1:0] XL_TX_OK_OUT,
  output logic [NUM_XLINKS-1:0][3:0] XL_DIR_OUT,
  output logic [NUM_XLINKS-1:0][1:0] XL_NET_OUT,
  output logic [NUM_PLINKS-1:0][1:0] PL_NET_OUT
);

  typedef struct packed {
    logic [15:0] sw_div;
    logic [15:0] ref_div;
    logic [15:0] sw_cnt;
    logic [15:0] ref_cnt;
    logic sw_tick;
    logic ref_tick;
    logic [15:0] node_id;
    logic [31:0] dir_lo;
    logic [31:0] dir_hi;
    logic [1:0] rsv_a;
    logic [1:0] rsv_b;
    logic dbg_rsv;
    logic [1:0] dbg_src;
    snl_pkg::snl_xlink_t [NUM_XLINKS-1:0] xl;
    logic [NUM_PLINKS-1:0][1:0] pl_net;
    logic [31:0] rdata;
    logic rvalid;
    logic route_valid;
    logic [3:0] route_dir;
    logic route_local;
  } snl_state_t;

  snl_state_t s;
  snl_state_t next_s;

  // Status word shared by both link kinds; direction added only for external links
  function automatic logic [31:0] stat_word(snl_pkg::snl_lstat_t st, logic [1:0] net);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`SNL_STAT_SRC_LSB +: 2] = st.src_type;
    w[`SNL_STAT_DEST_LSB +: 8] = st.dest_link;
    w[`SNL_STAT_NET_LSB +: 2] = net;
    w[`SNL_STAT_JUNK_BIT] = st.junk;
    w[`SNL_STAT_DBUSY_BIT] = st.dest_busy;
    w[`SNL_STAT_SBUSY_BIT] = st.src_busy;
    return w;
  endfunction : stat_word

  // Read mux; unused bits and unmapped numbers give zero, reserved fields read back their stored value
  function automatic logic [31:0] read_word(snl_state_t st, logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `SNL_REG_NODE_ID: w[15:0] = st.node_id;
      `SNL_REG_SW_DIV: w[15:0] = st.sw_div;
      `SNL_REG_REF_DIV: w[15:0] = st.ref_div;
      `SNL_REG_DEV_ID: w = DEVICE_ID;
      `SNL_REG_USER_CODE: w = {OTP_USER_CODE_IN, METAL_ID_IN};
      `SNL_REG_DIR_LO: w = st.dir_lo;
      `SNL_REG_DIR_HI: w = st.dir_hi;
      `SNL_REG_RSV_A: w[1:0] = st.rsv_a;
      `SNL_REG_RSV_B: w[1:0] = st.rsv_b;
      `SNL_REG_DBG_SRC: begin
        w[`SNL_DBG_RSV_BIT] = st.dbg_rsv;
        w[1:0] = st.dbg_src;
      end
      default: begin
        for (int i = 0; i < NUM_XLINKS; i++) begin
          if (a == 8'(`SNL_REG_XSTAT + i)) begin
            w = stat_word(XL_STAT_IN[i], st.xl[i].net);
            w[`SNL_STAT_DIR_LSB +: 4] = st.xl[i].dir;
          end
          if (a == 8'(`SNL_REG_XCTL + i)) begin
            w[`SNL_CTL_EN_BIT] = st.xl[i].enable;
            w[`SNL_CTL_FIVE_BIT] = st.xl[i].five_wire;
            w[`SNL_CTL_ERR_BIT] = XL_ERR_IN[i];
            w[`SNL_CTL_ISSUED_BIT] = XL_CREDIT_ISSUED_IN[i];
            w[`SNL_CTL_CREDIT_BIT] = st.xl[i].credit;
            w[`SNL_CTL_SYMGAP_LSB +: 11] = st.xl[i].sym_gap;
            w[`SNL_CTL_TOKGAP_LSB +: 11] = st.xl[i].tok_gap;
          end
        end
        for (int i = 0; i < NUM_PLINKS; i++) begin
          if (a == 8'(`SNL_REG_PSTAT + i)) begin
            w = stat_word(PL_STAT_IN[i], st.pl_net[i]);
          end
        end
      end
    endcase
    return w;
  endfunction : read_word

  always_comb begin
    logic [15:0] mism;
    logic [3:0] msb;
    logic wr;
    logic [31:0] d;
    logic [7:0] a;
    next_s = s;
    wr = CFG_REQ_IN.wr;
    d = CFG_REQ_IN.wdata;
    a = CFG_REQ_IN.addr;

    // Dividers count from zero up to the field, so a field of N divides by N+1
    next_s.sw_tick = 1'h0;
    if (s.sw_cnt >= s.sw_div) begin
      next_s.sw_cnt = 16'h0000;
      next_s.sw_tick = 1'h1;
    end else begin
      next_s.sw_cnt = s.sw_cnt + 16'h0001;
    end
    next_s.ref_tick = 1'h0;
    if (s.ref_cnt >= s.ref_div) begin
      next_s.ref_cnt = 16'h0000;
      next_s.ref_tick = 1'h1;
    end else begin
      next_s.ref_cnt = s.ref_cnt + 16'h0001;
    end

    // Read answer one cycle after the request
    next_s.rvalid = CFG_REQ_IN.rd;
    next_s.rdata = CFG_REQ_IN.rd ? read_word(s, a) : 32'h0000_0000;

    // Writes; read-only fields have no storage, except the credit bit which is stored but never loaded from a write, so writes to them vanish
    if (wr) begin
      case (a)
        `SNL_REG_NODE_ID: next_s.node_id = d[15:0];
        `SNL_REG_SW_DIV: next_s.sw_div = d[15:0];
        `SNL_REG_REF_DIV: next_s.ref_div = d[15:0];
        `SNL_REG_DIR_LO: next_s.dir_lo = d;
        `SNL_REG_DIR_HI: next_s.dir_hi = d;
        `SNL_REG_RSV_A: next_s.rsv_a = d[1:0];
        `SNL_REG_RSV_B: next_s.rsv_b = d[1:0];
        `SNL_REG_DBG_SRC: begin
          next_s.dbg_rsv = d[`SNL_DBG_RSV_BIT];
          next_s.dbg_src = d[1:0];
        end
        default: begin
          for (int i = 0; i < NUM_PLINKS; i++) begin
            if (a == 8'(`SNL_REG_PSTAT + i)) begin
              next_s.pl_net[i] = d[`SNL_STAT_NET_LSB +: 2];
            end
          end
        end
      endcase
    end

    // A debug event outranks a software write in the same cycle
    if (DBG_EVENT_IN != 2'h0) begin
      next_s.dbg_src = DBG_EVENT_IN;
    end

    for (int i = 0; i < NUM_XLINKS; i++) begin
      next_s.xl[i].token_a = 1'h0;
      next_s.xl[i].rx_reset = 1'h0;
      if (wr && a == 8'(`SNL_REG_XSTAT + i)) begin
        next_s.xl[i].dir = d[`SNL_STAT_DIR_LSB +: 4];
        next_s.xl[i].net = d[`SNL_STAT_NET_LSB +: 2];
      end
      if (wr && a == 8'(`SNL_REG_XCTL + i)) begin
        next_s.xl[i].enable = d[`SNL_CTL_EN_BIT];
        next_s.xl[i].five_wire = d[`SNL_CTL_FIVE_BIT];
        next_s.xl[i].sym_gap = d[`SNL_CTL_SYMGAP_LSB +: 11];
        next_s.xl[i].tok_gap = d[`SNL_CTL_TOKGAP_LSB +: 11];
        if (d[`SNL_CTL_TOKEN_A_BIT]) begin
          next_s.xl[i].credit = 1'h0;
          next_s.xl[i].token_a = 1'h1;
        end
        next_s.xl[i].rx_reset = d[`SNL_CTL_RXRST_BIT];
      end
      // Credit arriving with a clearing write is kept, so none is lost
      if (XL_CREDIT_GOT_IN[i]) begin
        next_s.xl[i].credit = 1'h1;
      end
      // Idle gap: counter loaded with field plus one, token gap wins a tie
      if (XL_TOK_SENT_IN[i]) begin
        next_s.xl[i].gap_cnt = {1'h0, s.xl[i].tok_gap} + 12'h001;
      end else if (XL_SYM_SENT_IN[i]) begin
        next_s.xl[i].gap_cnt = {1'h0, s.xl[i].sym_gap} + 12'h001;
      end else if (s.xl[i].gap_cnt != 12'h000) begin
        next_s.xl[i].gap_cnt = s.xl[i].gap_cnt - 12'h001;
      end
      next_s.xl[i].tx_ok = next_s.xl[i].enable && next_s.xl[i].credit
                           && (next_s.xl[i].gap_cnt == 12'h000);
    end

    // Route lookup; the highest differing bit picks the table entry
    mism = ROUTE_DEST_ID_IN ^ s.node_id;
    msb = 4'h0;
    for (int k = 0; k < 16; k++) begin
      if (mism[k]) begin
        msb = 4'(k);
      end
    end
    next_s.route_valid = ROUTE_REQ_IN;
    next_s.route_local = ROUTE_REQ_IN && (mism == 16'h0000);
    if (!ROUTE_REQ_IN || mism == 16'h0000) begin
      next_s.route_dir = 4'h0;
    end else if (msb[3]) begin
      next_s.route_dir = s.dir_hi[{msb[2:0], 2'h0} +: `SNL_DIR_W];
    end else begin
      next_s.route_dir = s.dir_lo[{msb[2:0], 2'h0} +: `SNL_DIR_W];
    end
  end

  // Clock enable low freezes everything, including the dividers
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      s <= '0;
      s.sw_div <= `SNL_SW_DIV_RST;
      s.ref_div <= `SNL_REF_DIV_RST;
      s.node_id <= `SNL_NODE_ID_RST;
    end else if (CLK_EN_IN) begin
      s <= next_s;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_XLINKS; i++) begin
      XL_ENABLE_OUT[i] = s.xl[i].enable;
      XL_FIVE_WIRE_OUT[i] = s.xl[i].five_wire;
      XL_TOKEN_A_OUT[i] = s.xl[i].token_a;
      XL_RX_RESET_OUT[i] = s.xl[i].rx_reset;
      XL_TX_OK_OUT[i] = s.xl[i].tx_ok;
      XL_DIR_OUT[i] = s.xl[i].dir;
      XL_NET_OUT[i] = s.xl[i].net;
    end
  end

  assign PL_NET_OUT = s.pl_net;
  assign CFG_RDATA_OUT = s.rdata;
  assign CFG_RVALID_OUT = s.rvalid;
  assign ROUTE_VALID_OUT = s.route_valid;
  assign ROUTE_DIR_OUT = s.route_dir;
  assign ROUTE_LOCAL_OUT = s.route_local;
  assign SWITCH_TICK_OUT = s.sw_tick;
  assign REF_TICK_OUT = s.ref_tick;

endmodule : snl_config_top

/* snl_remote_node.sv */
// Remote switch node model on the far side of an external serial link
`timescale 1ns/1ps
module snl_remote_node (
  input wire logic clk_in,
  input wire logic token_a_in,
  input wire logic [3:0] delay_in,
  output logic credit_out
);
  logic [4:0] cnt = 5'h00;
  initial credit_out = 1'b0;
  // Credit is issued only after token_a arrives; delay_in models a slow peer
  always @(posedge clk_in) begin
    credit_out <= (cnt == 5'h01);
    if (token_a_in) begin
      cnt <= {1'b0, delay_in} + 5'h01;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end
  end
endmodule : snl_remote_node

/* snl_config_chk.sv */
// Port-level assertions for the switch node config bank
`timescale 1ns/1ps
module snl_config_chk #(
  parameter int NUM_XLINKS = 9
) (
  input wire logic CORE_CLK_IN,
  input wire logic SRST_IN,
  input wire logic CLK_EN_IN,
  input wire snl_pkg::snl_cfg_req_t CFG_REQ_IN,
  input wire logic [31:0] CFG_RDATA_OUT,
  input wire logic CFG_RVALID_OUT,
  input wire logic [13:0] OTP_USER_CODE_IN,
  input wire logic [17:0] METAL_ID_IN,
  input wire logic ROUTE_REQ_IN,
  input wire logic ROUTE_VALID_OUT,
  input wire logic [NUM_XLINKS-1:0] XL_SYM_SENT_IN,
  input wire logic [NUM_XLINKS-1:0] XL_TOK_SENT_IN,
  input wire logic [NUM_XLINKS-1:0] XL_CREDIT_GOT_IN,
  input wire logic [NUM_XLINKS-1:0] XL_TOKEN_A_OUT,
  input wire logic [NUM_XLINKS-1:0] XL_RX_RESET_OUT,
  input wire logic [NUM_XLINKS-1:0] XL_TX_OK_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (SRST_IN);
  logic rd;
  logic wr0;
  assign rd = CLK_EN_IN && CFG_REQ_IN.rd;
  assign wr0 = CLK_EN_IN && CFG_REQ_IN.wr && CFG_REQ_IN.addr == 8'h80;
  a_unmapped_reads_zero: assert property (
    rd && CFG_REQ_IN.addr == 8'h30 |=> CFG_RVALID_OUT && CFG_RDATA_OUT == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_user_code_word: assert property (
    rd && CFG_REQ_IN.addr == 8'h0a |=> CFG_RDATA_OUT == {$past(OTP_USER_CODE_IN), $past(METAL_ID_IN)})
    else $error("user code word wrong");
  a_route_answer: assert property (
    CLK_EN_IN && ROUTE_REQ_IN |=> ROUTE_VALID_OUT)
    else $error("route lookup not answered");
  a_token_a_pulse: assert property (
    wr0 |=> XL_TOKEN_A_OUT[0] == $past(CFG_REQ_IN.wdata[24]))
    else $error("token_a pulse wrong");
  a_rx_reset_pulse: assert property (
    wr0 |=> XL_RX_RESET_OUT[0] == $past(CFG_REQ_IN.wdata[23]))
    else $error("receiver reset pulse wrong");
  a_token_a_drops_credit: assert property (
    $rose(XL_TOKEN_A_OUT[0]) && !$past(XL_CREDIT_GOT_IN[0]) |-> !XL_TX_OK_OUT[0])
    else $error("transmit allowed after credit clear");
  a_symbol_gap: assert property (
    CLK_EN_IN && XL_SYM_SENT_IN[0] |=> !XL_TX_OK_OUT[0])
    else $error("no idle after symbol");
  a_token_gap: assert property (
    CLK_EN_IN && XL_TOK_SENT_IN[0] |=> !XL_TX_OK_OUT[0])
    else $error("no idle after token");
endmodule : snl_config_chk
bind snl_config_top snl_config_chk #(.NUM_XLINKS(NUM_XLINKS)) u_chk (.*);

/* snl_tb.sv */
// Self-checking bench for the switch node config bank
`timescale 1ns/1ps
module testbench;
  logic clk, rst, rvalid, rv, rloc, rreq, ce;
  logic [1:0] tk;
  logic [8:0][1:0] xnet;
  logic [7:0][1:0] pnet;
  snl_pkg::snl_cfg_req_t req;
  logic [31:0] rdata;
  logic [13:0] otp;
  logic [17:0] metal;
  logic [1:0] dbg;
  logic [15:0] dest;
  logic [3:0] rdir, dly;
  snl_pkg::snl_lstat_t [8:0] xs;
  snl_pkg::snl_lstat_t [7:0] ps;
  logic [8:0] err, iss, sym, tok, en, five, hel, txok, rxr;
  wire logic [8:0] got;
  logic [8:0][3:0] xdir;
  logic [31:0] q[$];
  int n_mismatch = 0;
  int samples_checked = 0;
  snl_config_top dut (
    .CORE_CLK_IN(clk), .SRST_IN(rst), .CLK_EN_IN(ce), .CFG_REQ_IN(req),
    .CFG_RDATA_OUT(rdata), .CFG_RVALID_OUT(rvalid), .OTP_USER_CODE_IN(otp),
    .METAL_ID_IN(metal), .DBG_EVENT_IN(dbg), .ROUTE_REQ_IN(rreq), .ROUTE_DEST_ID_IN(dest),
    .ROUTE_VALID_OUT(rv), .ROUTE_DIR_OUT(rdir), .ROUTE_LOCAL_OUT(rloc), .SWITCH_TICK_OUT(tk[0]),
    .REF_TICK_OUT(tk[1]), .XL_STAT_IN(xs), .PL_STAT_IN(ps), .XL_ERR_IN(err),
    .XL_CREDIT_ISSUED_IN(iss), .XL_CREDIT_GOT_IN(got), .XL_SYM_SENT_IN(sym),
    .XL_TOK_SENT_IN(tok), .XL_ENABLE_OUT(en), .XL_FIVE_WIRE_OUT(five), .XL_TOKEN_A_OUT(hel),
    .XL_RX_RESET_OUT(rxr), .XL_TX_OK_OUT(txok), .XL_DIR_OUT(xdir), .XL_NET_OUT(xnet),
    .PL_NET_OUT(pnet));
  for (genvar i = 0; i < 9; i++) begin : g_peer
    snl_remote_node u_peer (.clk_in(clk), .token_a_in(hel[i]), .delay_in(dly), .credit_out(got[i]));
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    req = '{w, !w, a, d};
    @(negedge clk);
    req = '0;
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    acc(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  // Read data is judged where it settles, away from the launching edge
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (q.size() == 0) chk("rvalid", 32'h1, 32'h0);
      else chk("rdata", rdata, q.pop_front());
    end
  end
  initial begin
    #40000;
    n_mismatch++;
    summarize();
  end
  initial begin
    logic [31:0] lo, hi, v, ex;
    logic [15:0] nid;
    int g, n, c;
    rst = 1'b1; req = '0; otp = '0; metal = '0; dbg = '0; rreq = 1'b0; dest = '0; ce = 1'b1;
    xs = '0; ps = '0; err = '0; iss = '0; sym = '0; tok = '0; dly = 4'h8;
    void'($urandom(32'h428add74));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd(8'h07, 32'h0000_0000);
    rd(8'h08, 32'h0000_0003);
    rd(8'h05, 32'h0000_0000);
    rd(8'h0c, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    $display("test reset values done");
    acc(1'b1, 8'h07, 32'hffff_ffff);
    rd(8'h07, 32'h0000_ffff);
    acc(1'b1, 8'h08, 32'hffff_fffe);
    rd(8'h08, 32'h0000_fffe);
    otp = 14'($urandom);
    metal = 18'($urandom);
    acc(1'b1, 8'h0a, 32'hffff_ffff);
    rd(8'h0a, {otp, metal});
    acc(1'b1, 8'h30, 32'hffff_ffff);
    rd(8'h30, 32'h0000_0000);
    dbg = 2'b10;
    @(negedge clk);
    dbg = 2'b00;
    rd(8'h1f, 32'h0000_0002);
    acc(1'b1, 8'h1f, 32'h0000_0001);
    rd(8'h1f, 32'h0000_0001);
    $display("test access kinds done");
    nid = 16'($urandom);
    lo = $urandom;
    hi = $urandom;
    acc(1'b1, 8'h05, {16'h0000, nid});
    acc(1'b1, 8'h0c, lo);
    acc(1'b1, 8'h0d, hi);
    rd(8'h0d, hi);
    for (int k = 0; k < 17; k++) begin
      @(negedge clk);
      rreq = 1'b1;
      dest = nid ^ (16'h0001 << k) ^ (16'($urandom) & ((16'h0001 << k) - 16'h0001));
      if (k == 16) dest = nid;
      v = (k == 16) ? 32'h0000_0000 : (k < 8) ? lo >> (4 * k) : hi >> (4 * k - 32);
      @(negedge clk);
      rreq = 1'b0;
      chk("route", {26'h0, rv, rloc, rdir}, {26'h0, 1'b1, k == 16, v[3:0]});
    end
    $display("test routing done");
    for (int i = 0; i < 9; i++) begin
      xs[i] = 13'($urandom);
      v = $urandom;
      acc(1'b1, 8'h20 + 8'(i), v);
      rd(8'h20 + 8'(i), {6'h0, xs[i][12:3], 4'h0, v[11:8], 2'h0, v[5:4], 1'b0, xs[i][2:0]});
      chk("xl_dir", {28'h0, xdir[i]}, {28'h0, v[11:8]});
      chk("xl_net", {30'h0, xnet[i]}, {30'h0, v[5:4]});
      if (i < 8) begin
        ps[i] = 13'($urandom);
        acc(1'b1, 8'h40 + 8'(i), v);
        rd(8'h40 + 8'(i), {6'h0, ps[i][12:3], 10'h0, v[5:4], 1'b0, ps[i][2:0]});
        chk("pl_net", {30'h0, pnet[i]}, {30'h0, v[5:4]});
      end
    end
    $display("test link status done");
    g = $urandom_range(5);
    n = $urandom_range(5);
    err = 9'($urandom);
    iss = 9'($urandom);
    v = 32'hc180_0000 | (32'(g) << 11) | 32'(n);
    ex = (v & 32'hfe7f_ffff) | {4'h0, err[0], iss[0], 26'h0};
    acc(1'b1, 8'h80, v);
    chk("xl_mode", {30'h0, five[0], en[0]}, 32'h0000_0003);
    chk("pulse", {30'h0, rxr[0], hel[0]}, 32'h0000_0003);
    repeat (12) @(negedge clk);
    rd(8'h80, ex | 32'h0200_0000);
    acc(1'b1, 8'h80, v);
    rd(8'h80, ex);
    repeat (12) @(negedge clk);
    chk("tx_ok", {31'h0, txok[0]}, 32'h0000_0001);
    for (int j = 0; j < 2; j++) begin
      if (j == 0) sym[0] = 1'b1;
      else tok[0] = 1'b1;
      @(negedge clk);
      sym = '0;
      tok = '0;
      c = 0;
      while (txok[0] !== 1'b1 && c < 100) begin
        c++;
        @(negedge clk);
      end
      chk("gap", 32'(c), 32'((j == 0 ? g : n) + 1));
    end
    $display("test link control done");
    acc(1'b1, 8'h07, 32'(g));
    acc(1'b1, 8'h08, 32'(n));
    // Sync to one tick, then count the enabled cycles to the next one
    for (int j = 0; j < 2; j++) begin
      c = 0;
      while (tk[j] !== 1'b1 && c < 20) begin
        c++;
        @(negedge clk);
      end
      c = 1;
      @(negedge clk);
      while (tk[j] !== 1'b1 && c < 20) begin
        c++;
        @(negedge clk);
      end
      chk("tick", 32'(c), 32'((j == 0 ? g : n) + 1));
    end
    $display("test dividers done");
    // A write made while the enable is low must leave no trace
    ce = 1'b0;
    acc(1'b1, 8'h1f, 32'h0000_0003);
    ce = 1'b1;
    rd(8'h1f, 32'h0000_0001);
    @(negedge clk);
    @(negedge clk);
    chk("pending", 32'(q.size()), 32'h0000_0000);
    $display("test clock enable done");
    summarize();
  end
endmodule : testbench
